// File: hw/pcr_ratio_select.sv
/*
  pcr_ratio_select: samples ratio straps at the end of power-on reset and holds the
  decoded platform, core and memory clock ratios until the next power-on reset.
  assumes straps are asynchronous board pins, valid while sys_rst is high.
*/
`timescale 1ns/1ps
`default_nettype none
// Function
// - capture 4-bit platform code from address straps; sets platform clock multiple.
// - platform decode 0->16, 2..6, 8, 9, 10, 12, 13->20; others reserved.
// - capture 3-bit core code ordered bus control, address latch, general-purpose strap.
// - core decode 000 4:1, 001 9:2, 011..111 3:2..7:2; 010 reserved.
// - memory bus clock runs at half the platform clock.
module pcr_ratio_select
  import pcr_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // straps
  input wire logic [pcr_pkg::PLAT_W-1:0] platform_ratio_strap,
  input wire logic core_ratio_strap_msb,
  input wire logic core_ratio_strap_mid,
  input wire logic core_ratio_strap_lsb,
  // ratios out
  output var pcr_pkg::pcr_ratio_t ratio,
  output logic [pcr_pkg::PLAT_W-1:0] platCodeOut,
  output logic [pcr_pkg::CORE_W-1:0] coreCodeOut
);
  logic [PLAT_W+CORE_W-1:0] syncA_r;
  logic [PLAT_W+CORE_W-1:0] syncB_r;
  pcr_strap_t codes_r;
  pcr_strap_t codes_nxt;
  pcr_ratio_t ratio_r;
  pcr_ratio_t ratio_nxt;
  pcr_state_t state_r;
  pcr_state_t state_nxt;
  wire [MULT_W-1:0] platMult;
  wire [HALF_W-1:0] coreHalves;
  wire platBad;
  wire coreBad;
  wire [CORE_W-1:0] coreRaw;

  // strap order: bus control is the msb
  assign coreRaw = {core_ratio_strap_msb, core_ratio_strap_mid, core_ratio_strap_lsb};

  // two-flop synchroniser; straps are board pins with no relation to mclk
  always_ff @(posedge mclk) begin
    syncA_r <= {platform_ratio_strap, coreRaw};
    syncB_r <= syncA_r;
  end

  // latch sequence: the last sample while reset is high wins, then freeze
  always_comb begin
    case (state_r)
      PCR_RESET: state_nxt = sys_rst ? PCR_RESET : PCR_LATCH;
      PCR_LATCH: state_nxt = PCR_HOLD;
      PCR_HOLD: state_nxt = PCR_HOLD;
      default: state_nxt = PCR_RESET;
    endcase
  end

  // codes track the synchronised straps during reset only
  assign codes_nxt = (state_r == PCR_RESET) ? pcr_strap_t'(syncB_r) : codes_r;

  pcr_decode u_decode (
    .codes(codes_r),
    .platMult(platMult),
    .coreHalves(coreHalves),
    .platBad(platBad),
    .coreBad(coreBad)
  );

  always_comb begin
    ratio_nxt = ratio_r;
    if (state_r == PCR_LATCH) begin
      ratio_nxt.platMult = platMult;
      ratio_nxt.coreHalves = coreHalves;
      ratio_nxt.memDiv = MEM_DIV;
      ratio_nxt.platBad = platBad; // flags an violation by the board
      ratio_nxt.coreBad = coreBad;
      ratio_nxt.valid = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_r <= PCR_RESET;
      ratio_r <= '0;
    end else begin
      state_r <= state_nxt;
      ratio_r <= ratio_nxt;
    end
  end

  // codes keep following pins under reset, so no reset value here
  always_ff @(posedge mclk) begin
    codes_r <= codes_nxt;
  end

  assign ratio = ratio_r;
  assign platCodeOut = codes_r.platCode;
  assign coreCodeOut = codes_r.coreCode;

  property p_hold_after_latch;
    @(posedge mclk) disable iff (sys_rst)
      ratio_r.valid |=> $stable(ratio_r) && $stable(codes_r);
  endproperty
  a_hold_after_latch: assert property (p_hold_after_latch) else $error("ratios changed after latch");

  property p_valid_two_after_release;
    @(posedge mclk) $fell(sys_rst) |-> !ratio_r.valid ##1 !ratio_r.valid ##1 ratio_r.valid;
  endproperty
  a_valid_two_after_release: assert property (p_valid_two_after_release) else $error("valid timing wrong");

  property p_plat_16;
    @(posedge mclk) disable iff (sys_rst)
      (ratio_r.valid && codes_r.platCode == 4'h0) |-> ratio_r.platMult == 5'h10;
  endproperty
  a_plat_16: assert property (p_plat_16) else $error("code 0 not 16");

  property p_plat_20;
    @(posedge mclk) disable iff (sys_rst)
      (ratio_r.valid && codes_r.platCode == 4'hd) |-> ratio_r.platMult == 5'h14;
  endproperty
  a_plat_20: assert property (p_plat_20) else $error("code d not 20");

  property p_plat_reserved;
    @(posedge mclk) disable iff (sys_rst)
      ratio_r.valid |-> (ratio_r.platBad == (ratio_r.platMult == 5'h00));
  endproperty
  a_plat_reserved: assert property (p_plat_reserved) else $error("reserved platform flag wrong");

  property p_core_map;
    @(posedge mclk) disable iff (sys_rst)
      (ratio_r.valid && codes_r.coreCode == 3'h1) |-> ratio_r.coreHalves == 4'h9;
  endproperty
  a_core_map: assert property (p_core_map) else $error("core 001 not 9:2");

  property p_core_reserved;
    @(posedge mclk) disable iff (sys_rst)
      ratio_r.valid |-> (ratio_r.coreBad == (codes_r.coreCode == 3'h2));
  endproperty
  a_core_reserved: assert property (p_core_reserved) else $error("reserved core flag wrong");

  property p_mem_half;
    @(posedge mclk) disable iff (sys_rst)
      ratio_r.valid |-> ratio_r.memDiv == 2'h2;
  endproperty
  a_mem_half: assert property (p_mem_half) else $error("memory divider not 2");

  property p_capture_path;
    @(posedge mclk) $fell(sys_rst) |-> codes_r.platCode == $past(syncB_r[PLAT_W+CORE_W-1:CORE_W]);
  endproperty
  a_capture_path: assert property (p_capture_path) else $error("platform code not captured");

  property p_capture_core;
    @(posedge mclk)
      $fell(sys_rst) |-> codes_r.coreCode == $past(syncB_r[CORE_W-1:0]);
  endproperty
  a_capture_core: assert property (p_capture_core) else $error("core code not captured");

  property p_track_in_reset;
    @(posedge mclk)
      state_r == PCR_RESET |=> codes_r == $past(syncB_r);
  endproperty
  a_track_in_reset: assert property (p_track_in_reset) else $error("codes not tracking straps in reset");

  property p_plat_plain;
    @(posedge mclk) disable iff (sys_rst)
      (ratio_r.valid && codes_r.platCode inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha, 4'hc})
        |-> ratio_r.platMult == {1'b0, codes_r.platCode};
  endproperty
  a_plat_plain: assert property (p_plat_plain) else $error("plain platform code wrong multiple");

  property p_plat_res_codes;
    @(posedge mclk) disable iff (sys_rst)
      (ratio_r.valid && codes_r.platCode inside {4'h1, 4'h7, 4'hb, 4'he, 4'hf})
        |-> ratio_r.platBad && ratio_r.platMult == 5'h00;
  endproperty
  a_plat_res_codes: assert property (p_plat_res_codes) else $error("reserved platform code not flagged");

  property p_core_4to1;
    @(posedge mclk) disable iff (sys_rst)
      (ratio_r.valid && codes_r.coreCode == 3'h0) |-> ratio_r.coreHalves == 4'h8;
  endproperty
  a_core_4to1: assert property (p_core_4to1) else $error("core 000 not 4:1");

  property p_core_plain;
    @(posedge mclk) disable iff (sys_rst)
      (ratio_r.valid && codes_r.coreCode inside {3'h3, 3'h4, 3'h5, 3'h6, 3'h7})
        |-> ratio_r.coreHalves == {1'b0, codes_r.coreCode};
  endproperty
  a_core_plain: assert property (p_core_plain) else $error("core half ratio wrong");

  // a reserved core code must never look like a usable ratio downstream
  property p_core_zero;
    @(posedge mclk) disable iff (sys_rst)
      (ratio_r.valid && ratio_r.coreBad) |-> ratio_r.coreHalves == 4'h0;
  endproperty
  a_core_zero: assert property (p_core_zero) else $error("reserved core ratio not zero");

  property p_latch_one_cycle;
    @(posedge mclk) disable iff (sys_rst)
      state_r == PCR_LATCH |=> state_r == PCR_HOLD;
  endproperty
  a_latch_one_cycle: assert property (p_latch_one_cycle) else $error("latch state not single cycle");

  property p_valid_rise;
    @(posedge mclk) disable iff (sys_rst)
      $rose(ratio_r.valid) |-> $past(state_r) == PCR_LATCH;
  endproperty
  a_valid_rise: assert property (p_valid_rise) else $error("valid rose outside latch");

  property p_reset_clears;
    @(posedge mclk)
      sys_rst |=> state_r == PCR_RESET && !ratio_r.valid && ratio_r.platMult == PLAT_MULT_RST
        && ratio_r.coreHalves == CORE_HALF_RST;
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("reset did not clear ratios");

  // covers the latch cycle too, where valid is still low
  property p_codes_freeze;
    @(posedge mclk)
      state_r != PCR_RESET |=> $stable(codes_r);
  endproperty
  a_codes_freeze: assert property (p_codes_freeze) else $error("codes moved after release");
endmodule : pcr_ratio_select
`default_nettype wire

// File: hw/pcr_pkg.sv
/*
  pcr_pkg: constants and carrier types for the power-up clock ratio select block.
  assumes one clock domain (mclk) and a synchronous active-high reset.
*/
package pcr_pkg;
  localparam int PLAT_W = 4;
  localparam int CORE_W = 3;
  localparam int MULT_W = 5;
  // core ratio is carried in halves: 9:2 -> 9
  localparam int HALF_W = 4;
  localparam int MEMDIV_W = 2;
  localparam logic [MEMDIV_W-1:0] MEM_DIV = 2'h2;
  localparam logic [MULT_W-1:0] PLAT_MULT_RST = 5'h00;
  localparam logic [HALF_W-1:0] CORE_HALF_RST = 4'h0;

  typedef struct packed {
    logic [PLAT_W-1:0] platCode;
    logic [CORE_W-1:0] coreCode;
  } pcr_strap_t;

  typedef struct packed {
    logic [MULT_W-1:0] platMult;
    logic [HALF_W-1:0] coreHalves;
    logic [MEMDIV_W-1:0] memDiv;
    logic platBad;
    logic coreBad;
    logic valid;
  } pcr_ratio_t;

  typedef enum logic [1:0] {
    PCR_RESET = 2'b00,
    PCR_LATCH = 2'b01,
    PCR_HOLD = 2'b10
  } pcr_state_t;
endpackage : pcr_pkg

// File: hw/pcr_decode.sv
/*
  pcr_decode: combinational decode of the two strap codes into ratios.
  assumes codes are already synchronised and latched by the caller.
*/
`timescale 1ns/1ps
`default_nettype none
module pcr_decode
  import pcr_pkg::*;
(
  // codes in
  input wire pcr_pkg::pcr_strap_t codes,
  // decoded ratios
  output logic [pcr_pkg::MULT_W-1:0] platMult,
  output logic [pcr_pkg::HALF_W-1:0] coreHalves,
  output logic platBad,
  output logic coreBad
);
  always_comb begin
    platBad = 1'b0;
    case (codes.platCode)
      4'h0: platMult = 5'h10;
      4'h2: platMult = 5'h02;
      4'h3: platMult = 5'h03;
      4'h4: platMult = 5'h04;
      4'h5: platMult = 5'h05;
      4'h6: platMult = 5'h06;
      4'h8: platMult = 5'h08;
      4'h9: platMult = 5'h09;
      4'ha: platMult = 5'h0a;
      4'hc: platMult = 5'h0c;
      4'hd: platMult = 5'h14;
      default: begin
        platMult = 5'h00;
        platBad = 1'b1;
      end
    endcase
  end

  always_comb begin
    coreBad = 1'b0;
    case (codes.coreCode)
      3'h0: coreHalves = 4'h8;
      3'h1: coreHalves = 4'h9;
      3'h3: coreHalves = 4'h3;
      3'h4: coreHalves = 4'h4;
      3'h5: coreHalves = 4'h5;
      3'h6: coreHalves = 4'h6;
      3'h7: coreHalves = 4'h7;
      default: begin
        coreHalves = 4'h0;
        coreBad = 1'b1;
      end
    endcase
  end
endmodule : pcr_decode
`default_nettype wire

// File: verif/pcr_strap_board.sv
/*
  pcr_strap_board: board strap resistors presenting both ratio codes.
  assumes the bench only changes the requested codes on the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module pcr_strap_board
  import pcr_pkg::*;
(
  // requested codes
  input wire pcr_pkg::pcr_strap_t want,
  // strap pins
  output logic [pcr_pkg::PLAT_W-1:0] platPin,
  output logic [pcr_pkg::CORE_W-1:0] corePin
);
  // resistors give a steady level, never a floating pin
  assign platPin = want.platCode;
  // the bench picks reference and codes so the clock plan stays legal
  assign corePin = want.coreCode;
endmodule : pcr_strap_board
`default_nettype wire

// File: verif/pcr_ratio_select_test.sv
/*
  pcr_ratio_select_test: self-checking bench for the ratio select block.
  assumes the strap board model and a 200 MHz mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module pcr_ratio_select_test;
  import pcr_pkg::*;
  logic mclk = 1'b0;
  logic sysRst = 1'b1;
  pcr_strap_t want = '0;
  logic [PLAT_W-1:0] platPin;
  logic [CORE_W-1:0] corePin;
  pcr_ratio_t ratio;
  logic [PLAT_W-1:0] platCodeOut;
  logic [CORE_W-1:0] coreCodeOut;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  // reference clock of the board plan, in MHz
  localparam logic [15:0] REF_MHZ = 16'h0064;

  pcr_strap_board board (.want(want), .platPin(platPin), .corePin(corePin));
  pcr_ratio_select uut (.mclk(mclk), .sys_rst(sysRst), .platform_ratio_strap(platPin),
    .core_ratio_strap_msb(corePin[2]), .core_ratio_strap_mid(corePin[1]),
    .core_ratio_strap_lsb(corePin[0]), .ratio(ratio), .platCodeOut(platCodeOut),
    .coreCodeOut(coreCodeOut));

  initial begin
    forever #2.5 mclk = ~mclk;
  end

  task automatic final_report();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  // a hang must not pass silently
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [4:0] platExp(input logic [3:0] c);
    case (c)
      4'h0: return 5'h10;
      4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha, 4'hc: return {1'b0, c};
      4'hd: return 5'h14;
      default: return 5'h00;
    endcase
  endfunction : platExp

  function automatic logic [3:0] coreExp(input logic [2:0] c);
    case (c)
      3'h0: return 4'h8;
      3'h2: return 4'h0;
      3'h1: return 4'h9;
      default: return {1'b0, c};
    endcase
  endfunction : coreExp

  // reset long enough for the synchroniser, then wait past the load
  task automatic power_up(input pcr_strap_t s);
    @(negedge mclk);
    want = s;
    sysRst = 1'b1;
    repeat (4) @(negedge mclk);
    sysRst = 1'b0;
    repeat (4) @(negedge mclk);
  endtask : power_up

  task automatic test_plat();
    for (int i = 0; i < 16; i++) begin
      power_up({i[3:0], 3'h4});
      chk(16'(ratio.platMult), 16'(platExp(i[3:0])));
      chk(16'(ratio.platBad), 16'(platExp(i[3:0]) == 5'h00));
      chk(16'(platCodeOut), 16'(i[3:0]));
      chk(16'(ratio.memDiv), 16'h0002);
      chk(16'(ratio.valid), 16'h0001);
    end
  endtask : test_plat

  task automatic test_core();
    for (int i = 0; i < 8; i++) begin
      power_up({4'h2, i[2:0]});
      chk(16'(ratio.coreHalves), 16'(coreExp(i[2:0])));
      chk(16'(ratio.coreBad), 16'(i[2:0] == 3'h2));
      chk(16'(coreCodeOut), 16'(i[2:0]));
    end
  endtask : test_core

  // strap pins are shared, so later traffic on them must not leak in
  task automatic test_hold();
    power_up({4'h4, 3'h3});
    want = {4'hd, 3'h0};
    repeat (6) @(negedge mclk);
    chk(16'(ratio.platMult), 16'h0004);
    chk(16'(ratio.coreHalves), 16'h0003);
    chk(16'(platCodeOut), 16'h0004);
    sysRst = 1'b1;
    repeat (2) @(negedge mclk);
    chk(16'(ratio.valid), 16'h0000);
    sysRst = 1'b0;
    repeat (4) @(negedge mclk);
    chk(16'(ratio.platMult), 16'h0014);
  endtask : test_hold

  // legal board plan: 100 MHz reference, 4:1 platform (400), 2:1 core (800), memory 200
  task automatic test_board_plan();
    power_up({4'h4, 3'h4});
    chk(16'(ratio.platMult) * REF_MHZ, 16'h0190);
    chk(16'h0190 / 16'(ratio.memDiv), 16'h00c8);
    chk(16'h0190 * 16'(ratio.coreHalves) / 16'h0002, 16'h0320);
  endtask : test_board_plan

  initial begin
    repeat (2) @(negedge mclk);
    test_plat();
    test_core();
    test_hold();
    test_board_plan();
    final_report();
  end
endmodule : pcr_ratio_select_test
`default_nettype wire
